// *** ctr_defs.vh ***
// Register map, field positions and reset values of the status/routing block
`ifndef CTR_DEFS_VH
`define CTR_DEFS_VH

// Register indices (byte address is four times the index)
`define CTR_IDX_SELECT      5'h1C
`define CTR_IDX_PAIRING     5'h1D
`define CTR_IDX_STATUS      5'h1E
`define CTR_IDX_CHIPINFO    5'h1F

// Byte addresses on APB
`define CTR_ADDR_SELECT     8'h70
`define CTR_ADDR_PAIRING    8'h74
`define CTR_ADDR_STATUS     8'h78
`define CTR_ADDR_CHIPINFO   8'h7C

// Reset values
`define CTR_RST_SELECT      12'h000
`define CTR_RST_PAIRING     2'h0

// Select register fields
`define CTR_ARM_SEL_LSB     0
`define CTR_ARM_EN_BIT      3
`define CTR_START_SEL_LSB   4
`define CTR_START_EN_BIT    7
`define CTR_STOP_SEL_LSB    8
`define CTR_STOP_EN_BIT     11

// Pairing register fields
`define CTR_LOWER_PAIR_BIT  0
`define CTR_UPPER_PAIR_BIT  1

// Arbitrary chip information value
`define CTR_CHIP_INFO       16'h5A00

`endif

// *** ctr_measure_mux.v ***
// One time-measurement output: 8-to-1 comparator select with enable
`timescale 1ns/100ps
module ctr_measure_mux (
  // Comparator inputs, bit 2n high and 2n+1 low of channel n
  input  wire [7:0] compBus,
  // Control
  input  wire [2:0] selCode,
  input  wire       outEnable,
  // Tristate pin signals
  output wire       pinOut,
  output wire       pinOe
);

  assign pinOut = compBus[selCode];
  assign pinOe  = outEnable;

endmodule // ctr_measure_mux

// *** ctr_status_routing.v ***
// Channel status, channel pairing and measurement routing with APB slave
//
// Behaviour
// - Pairing bit 1 set multiplexes channel 3 onto channel 2; resets zero.
// - Pairing bit 0 set multiplexes channel 1 onto channel 0; upper unused.
// - Status bits 15:12 show OR of accumulated fail records, ch3..ch0.
// - Status bits 11:8 show OR of timing error flags, ch3..ch0.
// - Status bits 7,5,3,1 show live high comparators of ch3..ch0.
// - Status bits 6,4,2,0 show live low comparators of ch3..ch0.
// - Any comparator, high or low, can drive arm, start or stop.
// - Each measurement output has its own enable for high impedance.
// - Three independent multiplexers for arm, start and stop.
// - Select code 2n picks channel n high, 2n+1 channel n low.
// - Stop en 11 sel 10:8, start en 7 sel 6:4, arm en 3 sel 2:0.
// - Zero enable tristates output; enables and selects reset to zero.
`timescale 1ns/100ps
`include "ctr_defs.vh"
module ctr_status_routing (
  // Clock and reset
  input  wire        sys_clk,
  input  wire        reset_n,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [31:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  // Per-channel sources from the channel logic
  input  wire [3:0]  failRecordAny,
  input  wire [3:0]  timingErrorAny,
  // Comparator pins, asynchronous
  input  wire [3:0]  compHighPin,
  input  wire [3:0]  compLowPin,
  // Channel pairing controls
  output wire        upperPairMuxEnable,
  output wire        lowerPairMuxEnable,
  // Measurement outputs, two signals each
  output wire        measureArmOut,
  output wire        measureArmOe,
  output wire        measureStartOut,
  output wire        measureStartOe,
  output wire        measureStopOut,
  output wire        measureStopOe
);

  reg  [11:0] selectReg_r;
  reg  [1:0]  pairReg_r;
  reg  [3:0]  failSum_r;
  reg  [3:0]  timeErr_r;
  reg  [7:0]  compMeta_r;
  reg  [7:0]  compSync_r;
  reg  [31:0] prdata_nxt;
  wire [7:0]  compRaw;
  wire [7:0]  compBus;
  wire [15:0] statusWord;
  wire [7:0]  addrByte;
  wire        wrStrobe;
  wire        rdAccess;
  wire        addrHit;

  genvar ch;

  // Comparators interleaved: bit 2n high, 2n+1 low
  generate
    for (ch = 0; ch < 4; ch = ch + 1) begin : gInterleave
      assign compRaw[2*ch]   = compHighPin[ch];
      assign compRaw[2*ch+1] = compLowPin[ch];
    end
  endgenerate

  // Two-stage synchroniser for comparator pins
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      compMeta_r <= 8'h00;
      compSync_r <= 8'h00;
    end else begin
      compMeta_r <= compRaw;
      compSync_r <= compMeta_r;
    end
  end

  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      failSum_r <= 4'h0;
      timeErr_r <= 4'h0;
    end else begin
      failSum_r <= failRecordAny;
      timeErr_r <= timingErrorAny;
    end
  end

  // Status word assembly; each channel's high/low pair swapped so high lands on the odd bit
  assign statusWord = {failSum_r, timeErr_r, compSync_r[6], compSync_r[7],
                       compSync_r[4], compSync_r[5], compSync_r[2],
                       compSync_r[3], compSync_r[0], compSync_r[1]};

  // APB decode, zero wait states
  assign addrByte = paddr[7:0];
  assign addrHit  = (paddr[31:8] == 24'h000000) &&
                    (addrByte == `CTR_ADDR_SELECT ||
                     addrByte == `CTR_ADDR_PAIRING ||
                     addrByte == `CTR_ADDR_STATUS ||
                     addrByte == `CTR_ADDR_CHIPINFO);
  assign pready   = 1'b1;
  assign pslverr  = psel & penable & ~addrHit;
  assign wrStrobe = psel & penable & pwrite;
  assign rdAccess = psel & ~penable & ~pwrite;

  // Register writes
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      selectReg_r <= `CTR_RST_SELECT;
      pairReg_r   <= `CTR_RST_PAIRING;
    end else if (wrStrobe && paddr[31:8] == 24'h000000) begin
      if (addrByte == `CTR_ADDR_SELECT) begin
        selectReg_r <= pwdata[11:0];
      end else if (addrByte == `CTR_ADDR_PAIRING) begin
        pairReg_r <= pwdata[1:0];
      end
    end
  end

  // Read data mux, captured in setup cycle
  always @* begin
    prdata_nxt = 32'h00000000;
    if (paddr[31:8] != 24'h000000) begin
      prdata_nxt = 32'h00000000;
    end else if (addrByte == `CTR_ADDR_SELECT) begin
      prdata_nxt = {20'h00000, selectReg_r};
    end else if (addrByte == `CTR_ADDR_PAIRING) begin
      prdata_nxt = {30'h0000000, pairReg_r};
    end else if (addrByte == `CTR_ADDR_STATUS) begin
      prdata_nxt = {16'h0000, statusWord};
    end else if (addrByte == `CTR_ADDR_CHIPINFO) begin
      prdata_nxt = {16'h0000, `CTR_CHIP_INFO};
    end
  end

  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      prdata <= 32'h00000000;
    end else if (rdAccess) begin
      prdata <= prdata_nxt;
    end
  end

  assign upperPairMuxEnable = pairReg_r[`CTR_UPPER_PAIR_BIT];
  // Lower pair control, zero keeps channels independent
  assign lowerPairMuxEnable = pairReg_r[`CTR_LOWER_PAIR_BIT];

  // Synchronised comparators feed the measurement multiplexers
  assign compBus = compSync_r;

  ctr_measure_mux uArm (
    .compBus   (compBus),
    .selCode   (selectReg_r[`CTR_ARM_SEL_LSB+2:`CTR_ARM_SEL_LSB]),
    .outEnable (selectReg_r[`CTR_ARM_EN_BIT]),
    .pinOut    (measureArmOut),
    .pinOe     (measureArmOe)
  );

  ctr_measure_mux uStart (
    .compBus   (compBus),
    .selCode   (selectReg_r[`CTR_START_SEL_LSB+2:`CTR_START_SEL_LSB]),
    .outEnable (selectReg_r[`CTR_START_EN_BIT]),
    .pinOut    (measureStartOut),
    .pinOe     (measureStartOe)
  );

  ctr_measure_mux uStop (
    .compBus   (compBus),
    .selCode   (selectReg_r[`CTR_STOP_SEL_LSB+2:`CTR_STOP_SEL_LSB]),
    .outEnable (selectReg_r[`CTR_STOP_EN_BIT]),
    .pinOut    (measureStopOut),
    .pinOe     (measureStopOe)
  );

endmodule // ctr_status_routing

// *** ctr_status_routing_props.sv ***
// Port assertions for the status and routing block
`timescale 1ns/100ps
module ctr_status_routing_props (
  // Clock and bus
  input wire logic        sys_clk, reset_n, psel, penable, pwrite,
  input wire logic [31:0] paddr, pwdata,
  // Pins
  input wire logic [3:0]  compHighPin, compLowPin,
  input wire logic        upperPairMuxEnable, lowerPairMuxEnable,
  input wire logic        measureArmOut, measureStartOut, measureStopOut,
  input wire logic        measureArmOe, measureStartOe, measureStopOe
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  wire [7:0] c = {compLowPin[3], compHighPin[3], compLowPin[2],
    compHighPin[2], compLowPin[1], compHighPin[1], compLowPin[0],
    compHighPin[0]};
  wire       sw = psel & penable & pwrite & (paddr == 32'h70);
  wire       pw = psel & penable & pwrite & (paddr == 32'h74);
  wire [2:0] en = {pwdata[11], pwdata[7], pwdata[3]};
  wire [2:0] oe = {measureStopOe, measureStartOe, measureArmOe};
  wire [1:0] pr = {upperPairMuxEnable, lowerPairMuxEnable};
  property p_hi; pw |=> pr[1] == $past(pwdata[1]); endproperty
  a_hi: assert property (p_hi) else $error("upper pair");
  property p_lo; pw |=> pr[0] == $past(pwdata[0]); endproperty
  a_lo: assert property (p_lo) else $error("lower pair");
  property p_hold; !pw |=> $stable(pr); endproperty
  a_hold: assert property (p_hold) else $error("pair moved");
  property p_arm; sw |=> measureArmOut == c[$past(pwdata[2:0])]; endproperty
  a_arm: assert property (p_arm) else $error("arm route");
  property p_sta; sw |=> measureStartOut == c[$past(pwdata[6:4])]; endproperty
  a_sta: assert property (p_sta) else $error("start route");
  property p_sto; sw |=> measureStopOut == c[$past(pwdata[10:8])]; endproperty
  a_sto: assert property (p_sto) else $error("stop route");
  property p_oe; sw |=> oe == $past(en); endproperty
  a_oe: assert property (p_oe) else $error("enables");
  property p_rst; $rose(reset_n) |-> oe == 3'h0 && pr == 2'h0; endproperty
  a_rst: assert property (p_rst) else $error("reset state");
endmodule // ctr_status_routing_props
bind ctr_status_routing ctr_status_routing_props ctr_props_inst (.*);

// *** ctr_tmu_board.sv ***
// Board bus model in front of the time measurement unit
`timescale 1ns/100ps
module ctr_tmu_board (
  // Device pins
  input  wire logic       sys_clk,
  input  wire logic [2:0] pinOut, pinOe,
  // Bus to the unit
  output logic      [2:0] tmuBus
);
  logic [2:0] last_r = 3'h0;
  // board bus pick; a released bus shows the inverse of its last drive
  assign tmuBus = (pinOe & pinOut) | (~pinOe & ~last_r);
  always @(posedge sys_clk) last_r <= (pinOe & pinOut) | (~pinOe & last_r);
endmodule // ctr_tmu_board

// *** test_ctr_status_routing.sv ***
// Self-checking bench for the status and routing block
`timescale 1ns/100ps
module test_ctr_status_routing;
  logic        sys_clk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic [31:0] paddr = 0, pwdata = 0, prdata, rd;
  logic [3:0]  failRecordAny = 0, timingErrorAny = 0;
  logic [3:0]  compHighPin = 0, compLowPin = 0;
  logic        pready, pslverr, upperPairMuxEnable, lowerPairMuxEnable, err;
  logic        measureArmOut, measureArmOe, measureStartOut, measureStartOe;
  logic        measureStopOut, measureStopOe;
  logic [2:0]  tmuBus;
  logic [31:0] rows [4] = '{32'h0FE8A53A, 32'h01ADA51F, 32'h0C36A521,
                            32'h0BCF5A3F};
  int          errors = 0, comparisons = 0;
  always #25 sys_clk = ~sys_clk;
  ctr_status_routing ctr_status_routing_inst (.*);
  ctr_tmu_board ctr_tmu_board_inst (.sys_clk(sys_clk), .tmuBus(tmuBus),
    .pinOut({measureStopOut, measureStartOut, measureArmOut}),
    .pinOe({measureStopOe, measureStartOe, measureArmOe}));
  task automatic chk(input logic [31:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict;
    if (errors == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [31:0] a, d);
    int n;
    @(posedge sys_clk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1;
    for (n = 0; n < 9; n++) begin
      @(posedge sys_clk);
      if (pready === 1'b1) break;
    end
    if (n == 9) begin
      errors++;
      give_verdict;
    end
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  initial begin
    repeat (5) @(posedge sys_clk);
    reset_n <= 1;
    apb(0, 32'h70, 0);
    chk(rd, 0);
    apb(0, 32'h78, 0);
    chk(rd, 0);
    foreach (rows[i]) begin
      compHighPin <= rows[i][15:12];
      compLowPin <= rows[i][11:8];
      apb(1, 32'h70, rows[i][27:16]);
      apb(0, 32'h70, 0);
      chk(rd, rows[i][27:16]);
      chk({measureStopOe, measureStartOe, measureArmOe, measureStopOut,
        measureStartOut, measureArmOut}, rows[i][5:0]);
      chk(tmuBus & rows[i][5:3], rows[i][2:0] & rows[i][5:3]);
    end
    apb(1, 32'h74, 32'hFFFFFFFF);
    apb(0, 32'h74, 0);
    chk(rd, 3);
    chk({upperPairMuxEnable, lowerPairMuxEnable}, 3);
    apb(1, 32'h74, 1);
    apb(0, 32'h74, 0);
    chk({upperPairMuxEnable, lowerPairMuxEnable}, 1);
    failRecordAny <= 4'h9;
    timingErrorAny <= 4'h6;
    compHighPin <= 4'hA;
    compLowPin <= 4'h5;
    repeat (3) @(posedge sys_clk);
    apb(1, 32'h78, 0);
    apb(0, 32'h78, 0);
    chk(rd, 32'h9699);
    apb(0, 32'h80, 0);
    chk(err, 1);
    chk(rd, 0);
    reset_n <= 0;
    repeat (2) @(posedge sys_clk);
    reset_n <= 1;
    apb(0, 32'h74, 0);
    chk(rd, 0);
    give_verdict;
  end
endmodule // test_ctr_status_routing
